// ### hw/mcr_pkg.sv
// Package for the miscellaneous configuration register group.
// It assumes configuration accesses arrive as aligned dwords with byte enables.
package mcr_pkg;

  // Configuration dword addresses (byte offsets of the aligned dwords)
  localparam logic [7:0] MCR_DW_44 = 8'h44;
  localparam logic [7:0] MCR_DW_48 = 8'h48;
  localparam logic [7:0] MCR_DW_4C = 8'h4C;
  // Register byte offsets
  localparam logic [7:0] MCR_OFS_SEL_CTRL = 8'h46;
  localparam logic [7:0] MCR_OFS_STRAP = 8'h48;
  localparam logic [7:0] MCR_OFS_SERIRQ = 8'h4A;
  localparam logic [7:0] MCR_OFS_FREEZE = 8'h4C;

  // Reset values and writable masks
  localparam logic [15:0] MCR_SEL_CTRL_RST = 16'h0000;
  localparam logic [15:0] MCR_SEL_CTRL_WMASK = 16'h1E0F;
  localparam logic [15:0] MCR_STRAP_RST = 16'h0000;
  localparam logic [15:0] MCR_STRAP_WMASK = 16'h382C;
  localparam logic [7:0] MCR_SERIRQ_RST = 8'h10;
  localparam logic [7:0] MCR_SERIRQ_WMASK = 8'h7F;
  localparam logic [7:0] MCR_FREEZE_RST = 8'h00;
  localparam logic [7:0] MCR_FREEZE_WMASK = 8'h1F;

  // Chip select control fields
  localparam int MCR_SEL0_IO_BIT = 0;
  localparam int MCR_SEL0_MEM_BIT = 1;
  localparam int MCR_SEL1_IO_BIT = 2;
  localparam int MCR_SEL1_MEM_BIT = 3;
  localparam int MCR_IRQ12_LSB = 9;
  localparam int MCR_SEL0_UBM_BIT = 11;
  localparam int MCR_SEL1_UBM_BIT = 12;
  // Strap fields
  localparam int MCR_BIOS_BIT = 0;
  localparam int MCR_MUST_LOW_LSB = 2;
  localparam int MCR_MUST_HIGH_BIT = 5;
  localparam int MCR_LEGACY_PULL_BIT = 11;
  localparam int MCR_HOST_PULL_BIT = 12;
  localparam int MCR_DISK_PULL_BIT = 13;
  // Serial IRQ fields
  localparam int MCR_START_LEN_LSB = 0;
  localparam int MCR_FRAMES_LSB = 2;
  localparam int MCR_CONT_BIT = 6;
  // Freeze fields
  localparam int MCR_PIT_BIT = 0;
  localparam int MCR_RTC_BIT = 1;
  localparam int MCR_SIT_BIT = 3;
  localparam int MCR_PMT_BIT = 4;

  // Serial IRQ timing counts in clocks, and the base number of IRQ frames
  localparam logic [3:0] MCR_START_CLKS_0 = 4'h4;
  localparam logic [3:0] MCR_START_CLKS_1 = 4'h6;
  localparam logic [3:0] MCR_START_CLKS_2 = 4'h8;
  localparam logic [6:0] MCR_FRAME_BASE = 7'h11;
  localparam logic [1:0] MCR_FRAME_CLKS = 2'h3;
  localparam logic [3:0] MCR_STOP_CLKS = 4'h2;

  // IRQ12 pin definitions
  typedef enum logic [1:0] {
    MCR_PIN_IRQ12 = 2'h0,
    MCR_PIN_NONE = 2'h1,
    MCR_PIN_SMB_ALERT = 2'h2,
    MCR_PIN_USB_OC = 2'h3
  } mcr_pin_def_e;

  // Values latched at the rising edge of power good
  typedef struct packed {
    logic pull_en;
    logic must_low_hi;
    logic must_high;
  } mcr_strap_s;

  // Configuration access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } mcr_cfg_req_s;

endpackage

// ### hw/mcr_strap_latch.sv
// Strap latch: synchronises power good and strap pins, captures at release.
// Assumes the strap pins hold stable around the power-good rising edge.
`timescale 1ns/1ns
`default_nettype none
module mcr_strap_latch
  import mcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_power_good,
  input wire mcr_pkg::mcr_strap_s i_strap_pins,
  output var mcr_pkg::mcr_strap_s o_strap,
  output logic o_capture
);
  import mcr_pkg::*;

  logic [2:0] pg_sync;
  logic pg_state;
  mcr_strap_s pin_s1;
  mcr_strap_s pin_s2;
  mcr_strap_s pin_s3;
  wire pg_agree = (pg_sync[1] == pg_sync[2]);
  wire next_capture = pg_agree & pg_sync[2] & ~pg_state;

  // Three-flop synchronisers; only stages two and three are compared
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      pg_sync <= 3'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end
    else
    begin
      pg_sync <= {pg_sync[1:0], i_power_good};
      pin_s1 <= i_strap_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end

  // Capture on the trailing edge of the power-good reset
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      pg_state <= 1'b0;
      o_strap <= '0;
      o_capture <= 1'b0;
    end
    else
    begin
      if (pg_agree)
        pg_state <= pg_sync[2];
      o_capture <= next_capture;
      if (next_capture)
        o_strap <= pin_s3;
    end
endmodule
`default_nettype wire

// ### hw/mcr_serirq_seq.sv
// Serial IRQ cycle sequencer: start, IRQ frames, stop, restart.
// Assumes the slave start indication is already synchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none
module mcr_serirq_seq
  import mcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_start_pulse_len,
  input wire logic [3:0] i_frames,
  input wire logic i_continuous_mode_sel,
  input wire logic i_slave_start,
  output logic o_serirq_out,
  output logic o_serirq_oe,
  output logic o_in_cycle
);
  import mcr_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_START, S_FRAMES, S_STOP} mcr_sirq_state_e;
  mcr_sirq_state_e state;
  logic [6:0] cnt;
  logic [1:0] sub;
  // Reserved length code is run as the longest pulse
  wire [3:0] start_clks = (i_start_pulse_len == 2'h0) ? MCR_START_CLKS_0 :
                          (i_start_pulse_len == 2'h1) ? MCR_START_CLKS_1 : MCR_START_CLKS_2;
  wire [6:0] frame_total = MCR_FRAME_BASE + {3'h0, i_frames};
  wire go = i_continuous_mode_sel | i_slave_start;

  // Drive low during start and stop; frames belong to the slaves
  assign o_serirq_out = 1'b0;
  assign o_serirq_oe = (state == S_START) | (state == S_STOP);
  assign o_in_cycle = (state != S_IDLE);

  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      state <= S_IDLE;
      cnt <= 7'h00;
      sub <= 2'h0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (go)
          begin
            state <= S_START;
            cnt <= 7'h01;
          end
        S_START:
          if (cnt == {3'h0, start_clks})
          begin
            state <= S_FRAMES;
            cnt <= 7'h01;
            sub <= 2'h1;
          end
          else
            cnt <= cnt + 7'h01;
        S_FRAMES:
          if (sub == MCR_FRAME_CLKS)
          begin
            sub <= 2'h1;
            if (cnt == frame_total)
            begin
              state <= S_STOP;
              cnt <= 7'h01;
            end
            else
              cnt <= cnt + 7'h01;
          end
          else
            sub <= sub + 2'h1;
        S_STOP:
          if (cnt == {3'h0, MCR_STOP_CLKS})
          begin
            // Continuous mode chains straight into the next start frame
            state <= i_continuous_mode_sel ? S_START : S_IDLE;
            cnt <= 7'h01;
          end
          else
            cnt <= cnt + 7'h01;
      endcase
    end
endmodule
`default_nettype wire

// ### hw/mcr_regs.sv
// Miscellaneous configuration register group: chip-select control, strap
// latch, serial IRQ control and probe-ready timer freeze.
// Assumes configuration cycles come synchronous to the core clock as dwords.
// Function
// - Select0 IO enable decodes IO monitor three
// - Select0 memory enable uses memory monitor one
// - Select1 IO enable decodes IO monitor four
// - Select1 memory enable uses memory monitor two
// - Space bits inert without pin function
// - Two-bit field defines IRQ12 pin use
// - Select0 upper mask drops address bits 10:8
// - Select1 upper mask drops address bits 10:8
// - Strap defaults latched at power-good release
// - BIOS strap bit routes ROM accesses
// - Pull enables default from speaker strap
// - Start pulse lasts four, six, eight clocks
// - Seventeen plus field three-clock IRQ frames
// - Continuous mode restarts after each stop
// - Quiet mode waits for slave start
// - Probe-ready freezes selected counters when enabled
// - Bit zero halts interval timers
// - Bit one halts clock-calendar counters
// - Bits three, four halt inactivity, PM timers
// - Freeze bit two is plain storage
`timescale 1ns/1ns
`default_nettype none
module mcr_regs
  import mcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Configuration access
  input wire mcr_pkg::mcr_cfg_req_s i_cfg,
  output logic [31:0] o_cfg_rdata,
  // Pin-function selections from the pin-function registers
  input wire logic i_sel0_pin_function_reg,
  input wire logic i_sel1_pin_function_reg,
  input wire logic i_probe_pin_function_reg,
  // Cycle being decoded
  input wire logic i_io_cycle,
  input wire logic i_mem_cycle,
  input wire logic [15:0] i_io_addr,
  input wire logic [15:0] i_io_range3_base,
  input wire logic [7:0] i_io_range3_mask,
  input wire logic [15:0] i_io_range4_base,
  input wire logic [7:0] i_io_range4_mask,
  input wire logic i_mem_range1_hit,
  input wire logic i_mem_range2_hit,
  output logic o_periph_select_zero_n,
  output logic o_periph_select_one_n,
  output logic o_claim_to_isa,
  // IRQ12 pin
  input wire logic i_irq12_pin,
  output logic o_irq12_req,
  output logic o_irq12_pin_used,
  output logic o_smbus_alert_n,
  output logic o_usb_overcurrent_one_n,
  // Straps
  input wire logic i_power_good,
  input wire logic i_speaker_strap_pin,
  input wire logic i_rom_keyboard_select_n,
  input wire logic i_channel_ready_pin,
  input wire logic i_bios_route_pin,
  output logic o_rom_to_isa,
  output logic o_legacy_bus_pull_en,
  output logic o_host_bus_pull_en,
  output logic o_disk_bus_pull_en,
  // Serial IRQ
  input wire logic i_serirq_slave_start,
  output logic o_serirq_out,
  output logic o_serirq_oe,
  output logic o_serirq_active,
  // Probe-ready freezes
  input wire logic i_probe_ready,
  output logic o_interval_timer_halt,
  output logic o_clock_calendar_halt,
  output logic o_inactivity_timer_halt,
  output logic o_pm_timer_halt
);
  import mcr_pkg::*;

  localparam int SYNC_N = 3;

  logic [15:0] sel_ctrl;
  logic [15:0] strap_reg;
  logic [7:0] serirq_ctrl;
  logic [7:0] freeze;
  mcr_strap_s strap_val;
  logic strap_capture;

  // Pin inputs: three flops; a change is taken once stages two and three agree
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] pin_s1;
  logic [SYNC_N-1:0] pin_s2;
  logic [SYNC_N-1:0] pin_s3;
  logic [SYNC_N-1:0] pin_q;
  assign pin_raw = {i_bios_route_pin, i_probe_ready, i_irq12_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      // Stage one feeds stage two only, so no logic sees a metastable value
      always_ff @(posedge i_core_clk or negedge i_reset_n)
        if (!i_reset_n)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_q[gi] <= pin_s3[gi];
        end
    end
  endgenerate

  wire irq12_q = pin_q[0];
  wire probe_q = pin_q[1];
  wire bios_q = pin_q[2];

  // Strap capture at the rising edge of power good
  mcr_strap_latch u_strap (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_power_good(i_power_good),
    .i_strap_pins({i_speaker_strap_pin, i_rom_keyboard_select_n, i_channel_ready_pin}),
    .o_strap(strap_val),
    .o_capture(strap_capture)
  );

  // Address decode of the dword and its byte lanes
  wire hit_44 = (i_cfg.addr[7:2] == MCR_DW_44[7:2]);
  wire hit_48 = (i_cfg.addr[7:2] == MCR_DW_48[7:2]);
  wire hit_4c = (i_cfg.addr[7:2] == MCR_DW_4C[7:2]);
  wire wr_44 = i_cfg.wr & hit_44;
  wire wr_48 = i_cfg.wr & hit_48;
  wire wr_4c = i_cfg.wr & hit_4c;
  wire [15:0] be_sel = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}};
  wire [15:0] be_lo = {{8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};

  // Write merge: only enabled lanes and writable bits change
  wire [15:0] sel_wmask = be_sel & MCR_SEL_CTRL_WMASK;
  wire [15:0] next_sel_ctrl = (sel_ctrl & ~sel_wmask) | (i_cfg.wdata[31:16] & sel_wmask);
  wire [15:0] strap_wmask = be_lo & MCR_STRAP_WMASK;
  wire [15:0] next_strap_wr = (strap_reg & ~strap_wmask) | (i_cfg.wdata[15:0] & strap_wmask);
  wire [7:0] sirq_wmask = {8{i_cfg.be[2]}} & MCR_SERIRQ_WMASK;
  wire [7:0] next_serirq = (serirq_ctrl & ~sirq_wmask) | (i_cfg.wdata[23:16] & sirq_wmask);
  wire [7:0] frz_wmask = {8{i_cfg.be[0]}} & MCR_FREEZE_WMASK;
  wire [7:0] next_freeze = (freeze & ~frz_wmask) | (i_cfg.wdata[7:0] & frz_wmask);

  // Strap latch values land in their fields; capture wins over a write
  logic [15:0] strap_load;
  always_comb
  begin
    strap_load = next_strap_wr;
    strap_load[MCR_MUST_LOW_LSB+1] = strap_val.must_low_hi;
    strap_load[MCR_MUST_LOW_LSB] = 1'b0;
    strap_load[MCR_MUST_HIGH_BIT] = strap_val.must_high;
    strap_load[MCR_LEGACY_PULL_BIT] = strap_val.pull_en;
    strap_load[MCR_HOST_PULL_BIT] = strap_val.pull_en;
    strap_load[MCR_DISK_PULL_BIT] = strap_val.pull_en;
  end

  // Chip-select and strap registers
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      sel_ctrl <= MCR_SEL_CTRL_RST;
      strap_reg <= MCR_STRAP_RST;
    end
    else
    begin
      if (wr_44)
        sel_ctrl <= next_sel_ctrl;
      if (strap_capture)
        strap_reg <= strap_load;
      else if (wr_48)
        strap_reg <= next_strap_wr;
    end

  // Serial IRQ control and freeze registers
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      serirq_ctrl <= MCR_SERIRQ_RST;
      freeze <= MCR_FREEZE_RST;
    end
    else
    begin
      if (wr_48)
        serirq_ctrl <= next_serirq;
      if (wr_4c)
        freeze <= next_freeze;
    end

  // Read data: bit 0 of the strap register shows the live pin, not storage
  logic [15:0] strap_rd;
  always_comb
  begin
    strap_rd = strap_reg;
    strap_rd[MCR_BIOS_BIT] = bios_q;
  end
  wire [31:0] rd_mux = hit_44 ? {sel_ctrl, 16'h0000} :
                       hit_48 ? {8'h00, serirq_ctrl, strap_rd} :
                       hit_4c ? {24'h00_0000, freeze} : 32'h0000_0000;

  // Read data is registered so the answer follows the read by one clock
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
      o_cfg_rdata <= 32'h0000_0000;
    else if (i_cfg.rd)
      o_cfg_rdata <= rd_mux;

  // IO range compare; upper mask widens the mask into bits 10:8
  wire [15:0] mask3 = {5'h00, {3{sel_ctrl[MCR_SEL0_UBM_BIT]}}, i_io_range3_mask};
  wire [15:0] mask4 = {5'h00, {3{sel_ctrl[MCR_SEL1_UBM_BIT]}}, i_io_range4_mask};
  wire io3_hit = (((i_io_addr ^ i_io_range3_base) & ~mask3) == 16'h0000);
  wire io4_hit = (((i_io_addr ^ i_io_range4_base) & ~mask4) == 16'h0000);

  // Space bits only matter when the pin carries the select function
  wire sel0_io = i_sel0_pin_function_reg & sel_ctrl[MCR_SEL0_IO_BIT] & i_io_cycle & io3_hit;
  wire sel0_mem = i_sel0_pin_function_reg & sel_ctrl[MCR_SEL0_MEM_BIT] & i_mem_cycle & i_mem_range1_hit;
  wire sel1_io = i_sel1_pin_function_reg & sel_ctrl[MCR_SEL1_IO_BIT] & i_io_cycle & io4_hit;
  wire sel1_mem = i_sel1_pin_function_reg & sel_ctrl[MCR_SEL1_MEM_BIT] & i_mem_cycle & i_mem_range2_hit;

  // Selects are registered: one clock after the decoded cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_periph_select_zero_n <= 1'b1;
      o_periph_select_one_n <= 1'b1;
      o_claim_to_isa <= 1'b0;
    end
    else
    begin
      o_periph_select_zero_n <= ~(sel0_io | sel0_mem);
      o_periph_select_one_n <= ~(sel1_io | sel1_mem);
      o_claim_to_isa <= sel0_io | sel0_mem | sel1_io | sel1_mem;
    end

  // IRQ12 pin steering; unused destinations sit at their idle level
  mcr_pin_def_e pin_def;
  assign pin_def = mcr_pin_def_e'(sel_ctrl[MCR_IRQ12_LSB+1:MCR_IRQ12_LSB]);
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_irq12_req <= 1'b0;
      o_irq12_pin_used <= 1'b1;
      o_smbus_alert_n <= 1'b1;
      o_usb_overcurrent_one_n <= 1'b1;
    end
    else
    begin
      o_irq12_req <= (pin_def == MCR_PIN_IRQ12) & irq12_q;
      o_irq12_pin_used <= (pin_def != MCR_PIN_NONE);
      o_smbus_alert_n <= ~((pin_def == MCR_PIN_SMB_ALERT) & ~irq12_q);
      o_usb_overcurrent_one_n <= ~((pin_def == MCR_PIN_USB_OC) & ~irq12_q);
    end

  // Strap-driven controls
  assign o_rom_to_isa = bios_q;
  assign o_legacy_bus_pull_en = strap_reg[MCR_LEGACY_PULL_BIT];
  assign o_host_bus_pull_en = strap_reg[MCR_HOST_PULL_BIT];
  assign o_disk_bus_pull_en = strap_reg[MCR_DISK_PULL_BIT];

  // Serial IRQ cycle sequencing
  mcr_serirq_seq u_serirq (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_start_pulse_len(serirq_ctrl[MCR_START_LEN_LSB+1:MCR_START_LEN_LSB]),
    .i_frames(serirq_ctrl[MCR_FRAMES_LSB+3:MCR_FRAMES_LSB]),
    .i_continuous_mode_sel(serirq_ctrl[MCR_CONT_BIT]),
    .i_slave_start(i_serirq_slave_start),
    .o_serirq_out(o_serirq_out),
    .o_serirq_oe(o_serirq_oe),
    .o_in_cycle(o_serirq_active)
  );

  // Freezes apply only while probe-ready is active and its pin function chosen
  wire frz_on = i_probe_pin_function_reg & probe_q;
  assign o_interval_timer_halt = frz_on & freeze[MCR_PIT_BIT];
  assign o_clock_calendar_halt = frz_on & freeze[MCR_RTC_BIT];
  assign o_inactivity_timer_halt = frz_on & freeze[MCR_SIT_BIT];
  assign o_pm_timer_halt = frz_on & freeze[MCR_PMT_BIT];

endmodule
`default_nettype wire

// ### bench/mcr_regs_chk.sv
// Checker for the configuration register group, bound to the top ports.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module mcr_regs_chk
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_sel0_pin_function_reg,
  input wire logic i_sel1_pin_function_reg,
  input wire logic i_probe_pin_function_reg,
  input wire logic i_io_cycle,
  input wire logic i_mem_cycle,
  input wire logic [15:0] i_io_addr,
  input wire logic [15:0] i_io_range3_base,
  input wire logic [7:0] i_io_range3_mask,
  input wire logic i_mem_range1_hit,
  input wire logic o_periph_select_zero_n,
  input wire logic o_periph_select_one_n,
  input wire logic o_claim_to_isa,
  input wire logic o_irq12_req,
  input wire logic o_irq12_pin_used,
  input wire logic o_smbus_alert_n,
  input wire logic o_usb_overcurrent_one_n,
  input wire logic o_serirq_out,
  input wire logic o_serirq_oe,
  input wire logic o_serirq_active,
  input wire logic o_interval_timer_halt,
  input wire logic o_clock_calendar_halt,
  input wire logic o_inactivity_timer_halt,
  input wire logic o_pm_timer_halt
);
  logic [15:0] io_diff3;
  logic [3:0] hi_run;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Bits 10:8 always forgiven: a miss here misses under either mask
  assign io_diff3 = (i_io_addr ^ i_io_range3_base) & ~{5'h00, 3'h7, i_io_range3_mask};
  // Driven-clock run; saturates so a stuck line cannot wrap
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hi_run <= 4'h0;
    else if (!o_serirq_oe)
      hi_run <= 4'h0;
    else if (hi_run != 4'hF)
      hi_run <= hi_run + 4'h1;
  end
  sequence s_cycle_begin;
    !o_serirq_active ##1 o_serirq_active;
  endsequence
  sequence s_start_burst;
    o_serirq_oe [*4];
  endsequence
  a_sel0_pin_gate: assert property (!i_sel0_pin_function_reg |=> o_periph_select_zero_n)
    else $error("select zero asserted without its pin function");
  a_sel1_pin_gate: assert property (!i_sel1_pin_function_reg |=> o_periph_select_one_n)
    else $error("select one asserted without its pin function");
  a_sel0_io_miss: assert property (i_io_cycle && !i_mem_cycle && !i_mem_range1_hit && io_diff3 != 16'h0000
    |=> o_periph_select_zero_n) else $error("select zero asserted on an IO miss");
  a_claim_has_cycle: assert property (o_claim_to_isa |-> $past(i_io_cycle || i_mem_cycle))
    else $error("claim without a bus cycle");
  a_irq12_unused: assert property (!o_irq12_pin_used
    |-> !o_irq12_req && o_smbus_alert_n && o_usb_overcurrent_one_n) else $error("unused irq12 pin drives a function");
  a_alert_excl: assert property (!o_smbus_alert_n |-> o_usb_overcurrent_one_n && !o_irq12_req)
    else $error("alert active together with another pin function");
  a_start_min_len: assert property (s_cycle_begin |-> s_start_burst)
    else $error("start pulse shorter than four clocks");
  a_oe_run_bound: assert property (o_serirq_oe |-> hi_run < 4'hA)
    else $error("serial irq line driven longer than stop plus start");
  a_oe_in_cycle: assert property (o_serirq_oe |-> o_serirq_active && !o_serirq_out)
    else $error("serial irq line driven outside a cycle");
  a_halt_pin_gate: assert property (!i_probe_pin_function_reg && !$past(i_probe_pin_function_reg)
    |-> !(o_interval_timer_halt || o_clock_calendar_halt || o_inactivity_timer_halt || o_pm_timer_halt))
    else $error("timer halted without the probe pin function");
endmodule
bind mcr_regs mcr_regs_chk chk_u (.*);
`default_nettype wire

// ### bench/test_mcr_regs.sv
// Self-checking bench for the configuration register group.
// Assumes the top is driven directly through its dword configuration port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_mcr_regs;
  import mcr_pkg::*;
  logic i_core_clk, i_reset_n, i_sel0_pin_function_reg, i_sel1_pin_function_reg, i_probe_pin_function_reg;
  logic i_io_cycle, i_mem_cycle, i_mem_range1_hit, i_mem_range2_hit, i_irq12_pin, i_power_good;
  logic i_speaker_strap_pin, i_rom_keyboard_select_n, i_channel_ready_pin, i_bios_route_pin;
  logic i_serirq_slave_start, i_probe_ready;
  logic [15:0] i_io_addr, i_io_range3_base, i_io_range4_base;
  logic [7:0] i_io_range3_mask, i_io_range4_mask;
  mcr_cfg_req_s i_cfg;
  logic [31:0] o_cfg_rdata;
  logic o_periph_select_zero_n, o_periph_select_one_n, o_claim_to_isa, o_irq12_req, o_irq12_pin_used;
  logic o_smbus_alert_n, o_usb_overcurrent_one_n, o_rom_to_isa, o_legacy_bus_pull_en, o_host_bus_pull_en;
  logic o_disk_bus_pull_en, o_serirq_out, o_serirq_oe, o_serirq_active;
  logic o_interval_timer_halt, o_clock_calendar_halt, o_inactivity_timer_halt, o_pm_timer_halt;
  int miscompares, n_checks, hi1, lo, hi2;
  logic [7:0] fz [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1F};
  wire logic [3:0] halts = {o_pm_timer_halt, o_inactivity_timer_halt, o_clock_calendar_halt, o_interval_timer_halt};
  wire logic [3:0] straps = {o_rom_to_isa, o_legacy_bus_pull_en, o_host_bus_pull_en, o_disk_bus_pull_en};
  wire logic [3:0] irq_outs = {o_irq12_req, o_irq12_pin_used, o_smbus_alert_n, o_usb_overcurrent_one_n};
  mcr_regs dut_u (.*);
  always #20 i_core_clk = ~i_core_clk;
  // Inputs always move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Spare cycle: a strobe is never driven twice in one step
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    i_cfg = '{1'b1, 1'b0, a, be, d};
    tick(1);
    i_cfg = '0;
    tick(1);
  endtask
  task automatic cfg_chk(input logic [7:0] a, input logic [31:0] ex);
    i_cfg = '{1'b0, 1'b1, a, 4'h0, 32'h0000_0000};
    tick(1);
    i_cfg = '0;
    `CHK("cfg_rdata", ex, o_cfg_rdata)
    tick(1);
  endtask
  task automatic cs_case(input logic [5:0] ctl, input logic [15:0] a, input logic [2:0] ex);
    {i_sel0_pin_function_reg, i_sel1_pin_function_reg, i_io_cycle, i_mem_cycle, i_mem_range1_hit,
      i_mem_range2_hit} = ctl;
    i_io_addr = a;
    tick(2);
    `CHK("select_claim", ex, {o_periph_select_zero_n, o_periph_select_one_n, o_claim_to_isa})
  endtask
  // Bounded: a stuck line ends the run as a mismatch
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (o_serirq_oe === lvl)
    begin
      n++;
      tick(1);
      if (n > 300)
      begin
        miscompares++;
        give_verdict();
      end
    end
  endtask
  task automatic serirq_quiet(input logic [1:0] code, input logic [3:0] fr);
    cfg_wr(8'h48, 4'h4, {8'h00, 2'b00, fr, code, 16'h0000});
    tick(20);
    `CHK("serirq_idle", 1'b0, o_serirq_active)
    i_serirq_slave_start = 1'b1;
    tick(1);
    i_serirq_slave_start = 1'b0;
    run_len(1'b0, lo);
    run_len(1'b1, hi1);
    run_len(1'b0, lo);
    run_len(1'b1, hi2);
    `CHK("start_len", (code == 2'h3) ? 8 : 4 + 2 * code, hi1)
    `CHK("frame_gap", (17 + fr) * 3, lo)
    `CHK("stop_len", 2, hi2)
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    i_reset_n = 1'b0;
    {i_cfg, i_sel0_pin_function_reg, i_sel1_pin_function_reg, i_probe_pin_function_reg, i_io_cycle, i_mem_cycle,
      i_mem_range1_hit, i_mem_range2_hit, i_irq12_pin, i_power_good, i_speaker_strap_pin, i_rom_keyboard_select_n,
      i_channel_ready_pin, i_bios_route_pin, i_serirq_slave_start, i_probe_ready, i_io_addr, i_io_range4_mask} = 0;
    i_io_range3_base = 16'h0300;
    i_io_range3_mask = 8'h0F;
    i_io_range4_base = 16'h0310;
    tick(2);
    i_reset_n = 1'b1;
    tick(1);
    // Reset values, write masks and an unmapped dword
    cfg_chk(8'h44, 32'h0000_0000);
    cfg_chk(8'h48, 32'h0010_0000);
    cfg_chk(8'h4C, 32'h0000_0000);
    cfg_wr(8'h44, 4'hF, 32'hFFFF_FFFF);
    cfg_chk(8'h44, 32'h1E0F_0000);
    cfg_wr(8'h4C, 4'hF, 32'hFFFF_FFFF);
    cfg_chk(8'h4C, 32'h0000_001F);
    cfg_wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    cfg_chk(8'h40, 32'h0000_0000);
    $display("registers done");
    // Straps taken at each power-good release, both polarities
    {i_speaker_strap_pin, i_channel_ready_pin, i_rom_keyboard_select_n, i_bios_route_pin} = 4'b1101;
    tick(1);
    i_power_good = 1'b1;
    tick(8);
    cfg_chk(8'h48, 32'h0010_3821);
    `CHK("strap_outputs", 4'hF, straps)
    i_power_good = 1'b0;
    {i_speaker_strap_pin, i_channel_ready_pin, i_rom_keyboard_select_n, i_bios_route_pin} = 4'b0010;
    tick(6);
    i_power_good = 1'b1;
    tick(8);
    cfg_chk(8'h48, 32'h0010_0008);
    `CHK("strap_outputs", 4'h0, straps)
    cfg_wr(8'h48, 4'h3, 32'hFFFF_FFFF);
    cfg_chk(8'h48, 32'h0010_382C);
    $display("straps done");
    // Chip-select decode: hits, upper masks, pin-function gating
    cfg_wr(8'h44, 4'hC, 32'h080F_0000);
    cs_case(6'b111000, 16'h0305, 3'b011);
    cs_case(6'b111000, 16'h0705, 3'b011);
    cs_case(6'b111000, 16'h0310, 3'b101);
    cs_case(6'b111000, 16'h0710, 3'b110);
    cs_case(6'b110110, 16'h0000, 3'b011);
    cs_case(6'b110101, 16'h0000, 3'b101);
    cs_case(6'b011000, 16'h0305, 3'b110);
    cs_case(6'b101000, 16'h0310, 3'b110);
    cs_case(6'b010110, 16'h0000, 3'b110);
    cfg_wr(8'h44, 4'hC, 32'h1000_0000);
    cs_case(6'b111000, 16'h0310, 3'b110);
    cfg_wr(8'h44, 4'hC, 32'h100F_0000);
    cs_case(6'b111000, 16'h0710, 3'b101);
    $display("chip select done");
    // Every pin definition, pin high then low
    for (int m = 0; m < 4; m++)
    begin
      cfg_wr(8'h44, 4'hC, {16'(m << 9), 16'h0000});
      i_irq12_pin = 1'b1;
      tick(8);
      `CHK("irq12_high", {m == 0, m != 1, 2'b11}, irq_outs)
      i_irq12_pin = 1'b0;
      tick(8);
      `CHK("irq12_low", {1'b0, m != 1, m != 2, m != 3}, irq_outs)
    end
    $display("irq12 done");
    // Freeze bits one at a time, then all five together, under an active probe, then each gate removed
    {i_probe_pin_function_reg, i_probe_ready} = 2'b11;
    for (int v = 0; v < 6; v++)
    begin
      cfg_wr(8'h4C, 4'h1, {24'h00_0000, fz[v]});
      tick(6);
      `CHK("halts", {fz[v][4], fz[v][3], fz[v][1], fz[v][0]}, halts)
      cfg_chk(8'h4C, {24'h00_0000, fz[v]});
    end
    i_probe_ready = 1'b0;
    tick(6);
    `CHK("halts", 4'h0, halts)
    {i_probe_pin_function_reg, i_probe_ready} = 2'b01;
    tick(6);
    `CHK("halts", 4'h0, halts)
    $display("freeze done");
    // Quiet cycles for each start code, then continuous restart
    serirq_quiet(2'h0, 4'h0);
    serirq_quiet(2'h1, 4'hF);
    serirq_quiet(2'h2, 4'h5);
    serirq_quiet(2'h3, 4'h0);
    cfg_wr(8'h48, 4'h4, 32'h0040_0000);
    run_len(1'b0, lo);
    run_len(1'b1, hi1);
    run_len(1'b0, lo);
    run_len(1'b1, hi2);
    `CHK("restart_run", 6, hi2)
    `CHK("frame_gap", 51, lo)
    $display("serial irq done");
    give_verdict();
  end
endmodule
`default_nettype wire
